/* tccr_pkg.sv */
// tuner chip configuration register constants, field positions and decode helpers
package tccr_pkg;

  // apb data and address widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_DECIM = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_CHIP = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_DECIM = {IDX_DECIM[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHIP = {IDX_CHIP[ADDR_W-3:0], 2'b00};

  // reset values and implemented-bit masks (reserved bits read zero)
  localparam logic [DATA_W-1:0] RST_DECIM = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CHIP = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_DECIM = 32'h007F_FFFF;
  localparam logic [DATA_W-1:0] MASK_CHIP = 32'h0000_7FFF;
  localparam int DECIM_USED_W = 23;

  // chip configuration field positions
  localparam int BIT_LVL_SENSE = 0;
  localparam int BIT_AGC_DIS = 1;
  localparam int BIT_AGC_SENSE = 2;
  localparam int FLD_CAR_W = 3;
  localparam int FLD_RES_W = 5;
  localparam int BIT_CAR_EN = 7;
  localparam int BIT_RES_EN = 8;
  localparam int BIT_SYN_ACC = 9;
  localparam int BIT_RES_ACC = 10;
  localparam int FLD_SPH_SEL = 11;
  localparam int BIT_SPH_CONT = 13;
  localparam int BIT_CLEAR = 14;

  // sample phase tap: five bits starting at bit 24 plus the select
  localparam int SPH_BASE = 24;
  localparam int SPH_W = 5;

  // one clear line per affected accumulator or counter
  localparam int CLR_CARRIER = 0;
  localparam int CLR_CIC = 1;
  localparam int CLR_AGC = 2;
  localparam int CLR_SER_CNT = 3;
  localparam int CLR_SER_CLK = 4;
  localparam int CLR_RES_DIV = 5;
  localparam int CLR_N = 6;

  // offset frequency word width codes
  typedef enum logic [1:0] {
    W_8 = 2'b00,
    W_16 = 2'b01,
    W_24 = 2'b10,
    W_32 = 2'b11
  } tccr_width_t;

  // mask keeping the low bits of an offset word for a width code
  function automatic logic [DATA_W-1:0] width_mask(input tccr_width_t sel);
    unique case (sel)
      W_8: width_mask = 32'h0000_00FF;
      W_16: width_mask = 32'h0000_FFFF;
      W_24: width_mask = 32'h00FF_FFFF;
      W_32: width_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

endpackage

/* tccr_offset_gate.sv */
// offset frequency word gate: width truncation and enable
`timescale 1ns/100ps
module tccr_offset_gate #(
  parameter int W = 32
) (
  input wire logic [W-1:0] raw_word, // offset word from the datapath
  input wire logic [1:0] width_sel, // width code from configuration
  input wire logic enable, // offset enable bit
  output logic [W-1:0] gated_word // word the nco should add
);

  // disabled offset reads as zero, otherwise only the selected low bits pass
  always_comb begin
    if (enable) begin
      gated_word = raw_word & W'(tccr_pkg::width_mask(tccr_pkg::tccr_width_t'(width_sel)));
    end else begin
      gated_word = '0;
    end
  end

endmodule // tccr_offset_gate

/* tccr_phase_sel.sv */
// sample phase tap: picks five of the top eight phase accumulator bits
`timescale 1ns/100ps
module tccr_phase_sel #(
  parameter int ACC_W = 32,
  parameter int OUT_W = tccr_pkg::SPH_W
) (
  input wire logic [ACC_W-1:0] phase_acc, // re-sampler phase accumulator
  input wire logic [1:0] tap_sel, // tap select code
  output logic [OUT_W-1:0] phase_tap // selected five bits
);

  // shift rather than a mux keeps all four taps in one expression
  assign phase_tap = OUT_W'(phase_acc >> (tccr_pkg::SPH_BASE + int'(tap_sel)));

endmodule // tccr_phase_sel

/* tccr_top.sv */
// tuner chip configuration register bank with apb access and decoded controls
`timescale 1ns/100ps

// Function
// - bit 0 sets level compare output polarity
// - bit 1 disables gain loop, unity gain
// - bit 2 sets gain loop error sign
// - bits 4-3 set carrier offset word width
// - bits 6-5 set re-sampler offset width
// - bits 7-8 enable offsets, else zero
// - bits 9-10 enable nco accumulation feedback
// - bits 12-11 pick sample phase tap
// - bit 13 continuous or valid-gated phase update
// - bit 14 holds accumulators at zero
// - clear reaches six accumulators and counters
module tccr_top #(
  parameter int LVL_W = 10, // level detector sample width
  parameter int AGC_W = 10, // gain loop magnitude width
  parameter int ACC_W = 32 // nco word width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tccr_pkg::ADDR_W-1:0] paddr,
  input wire logic [tccr_pkg::DATA_W-1:0] pwdata,
  output logic [tccr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LVL_W-1:0] level_in,
  input wire logic [LVL_W-1:0] level_threshold,
  output logic level_compare_out,
  input wire logic [AGC_W-1:0] agc_level,
  input wire logic [AGC_W-1:0] agc_threshold,
  output logic agc_gain_unity,
  output logic agc_error_pos,
  input wire logic [ACC_W-1:0] carrier_offset_in,
  input wire logic [ACC_W-1:0] resamp_offset_in,
  output logic [ACC_W-1:0] carrier_offset_out,
  output logic [ACC_W-1:0] resamp_offset_out,
  output logic synth_accum_en,
  output logic resamp_accum_en,
  input wire logic [ACC_W-1:0] resamp_phase_acc,
  input wire logic output_data_valid,
  input wire logic sample_strobe_in,
  output logic [tccr_pkg::SPH_W-1:0] sample_phase_out,
  output logic sample_strobe_out,
  output logic [tccr_pkg::CLR_N-1:0] clear_targets,
  output logic [tccr_pkg::DECIM_USED_W-1:0] decim_filter_cfg
);

  // register state
  logic [tccr_pkg::DATA_W-1:0] chip_q; // chip configuration
  logic [tccr_pkg::DATA_W-1:0] decim_q; // decimating filter configuration
  logic [tccr_pkg::DATA_W-1:0] prdata_q; // read data, loaded in setup
  logic pready_q; // high for the single access cycle
  logic pslverr_q; // error for unmapped addresses
  logic live_q; // one after the first edge out of reset

  // decoded outputs, all held in flops
  logic level_q;
  logic agc_unity_q;
  logic agc_pos_q;
  logic [ACC_W-1:0] car_off_q;
  logic [ACC_W-1:0] res_off_q;
  logic syn_acc_q;
  logic res_acc_q;
  logic [tccr_pkg::SPH_W-1:0] sph_q;
  logic sample_strobe_out_q;
  logic [tccr_pkg::CLR_N-1:0] clr_q;

  // combinational helpers
  logic setup_cyc; // apb setup phase
  logic wr_done; // write takes effect this edge
  logic hit_chip; // address decodes to chip configuration
  logic hit_decim; // address decodes to filter configuration
  logic [ACC_W-1:0] car_off_d;
  logic [ACC_W-1:0] res_off_d;
  logic [tccr_pkg::SPH_W-1:0] sph_d;

  assign setup_cyc = psel & ~penable;
  assign wr_done = psel & penable & pready_q & pwrite;
  assign hit_chip = (paddr == tccr_pkg::ADDR_CHIP);
  assign hit_decim = (paddr == tccr_pkg::ADDR_DECIM);

  // apb handshake: ready rises in the first access cycle, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_cyc;
      pslverr_q <= setup_cyc & ~(hit_chip | hit_decim);
    end
  end

  // read data is captured in setup so it already reflects a write just finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_cyc && !pwrite) begin
      if (hit_chip) begin
        prdata_q <= chip_q;
      end else if (hit_decim) begin
        prdata_q <= decim_q;
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // register writes; reserved bits are dropped so they never steer anything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_q <= tccr_pkg::RST_CHIP;
      decim_q <= tccr_pkg::RST_DECIM;
    end else if (wr_done) begin
      if (hit_chip) begin
        chip_q <= pwdata & tccr_pkg::MASK_CHIP;
      end
      if (hit_decim) begin
        decim_q <= pwdata & tccr_pkg::MASK_DECIM;
      end
    end
  end

  // helper for checks: masks the first edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  // level detector polarity and gain loop controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      agc_unity_q <= 1'b0;
      agc_pos_q <= 1'b0;
    end else begin
      if (chip_q[tccr_pkg::BIT_LVL_SENSE]) begin
        level_q <= (level_in > level_threshold);
      end else begin
        level_q <= (level_in <= level_threshold);
      end
      agc_unity_q <= chip_q[tccr_pkg::BIT_AGC_DIS];
      // sense 1 gives +1 above threshold; sense 0 flips the sign
      agc_pos_q <= (agc_level > agc_threshold) == chip_q[tccr_pkg::BIT_AGC_SENSE];
    end
  end

  // carrier offset gate
  tccr_offset_gate #(
    .W(ACC_W)
  ) u_car_gate (
    .raw_word(carrier_offset_in),
    .width_sel(chip_q[tccr_pkg::FLD_CAR_W +: 2]),
    .enable(chip_q[tccr_pkg::BIT_CAR_EN]),
    .gated_word(car_off_d)
  );

  // re-sampler offset gate, same width encoding as the carrier
  tccr_offset_gate #(
    .W(ACC_W)
  ) u_res_gate (
    .raw_word(resamp_offset_in),
    .width_sel(chip_q[tccr_pkg::FLD_RES_W +: 2]),
    .enable(chip_q[tccr_pkg::BIT_RES_EN]),
    .gated_word(res_off_d)
  );

  // offset words and nco feedback enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_off_q <= '0;
      res_off_q <= '0;
      syn_acc_q <= 1'b0;
      res_acc_q <= 1'b0;
    end else begin
      car_off_q <= car_off_d;
      res_off_q <= res_off_d;
      // software is expected to keep these set; zero only kills feedback
      syn_acc_q <= chip_q[tccr_pkg::BIT_SYN_ACC];
      res_acc_q <= chip_q[tccr_pkg::BIT_RES_ACC];
    end
  end

  // phase tap selection
  tccr_phase_sel #(
    .ACC_W(ACC_W),
    .OUT_W(tccr_pkg::SPH_W)
  ) u_phase_sel (
    .phase_acc(resamp_phase_acc),
    .tap_sel(chip_q[tccr_pkg::FLD_SPH_SEL +: 2]),
    .phase_tap(sph_d)
  );

  // phase pins and strobe move freely or only with output data valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sph_q <= '0;
      sample_strobe_out_q <= 1'b0;
    end else if (chip_q[tccr_pkg::BIT_SPH_CONT] || output_data_valid) begin
      sph_q <= sph_d;
      sample_strobe_out_q <= sample_strobe_in;
    end
  end

  // clear is a level: it holds every target at zero until software drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= '0;
    end else begin
      clr_q <= {tccr_pkg::CLR_N{chip_q[tccr_pkg::BIT_CLEAR]}};
    end
  end

  // port drives, each straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign level_compare_out = level_q;
  assign agc_gain_unity = agc_unity_q;
  assign agc_error_pos = agc_pos_q;
  assign carrier_offset_out = car_off_q;
  assign resamp_offset_out = res_off_q;
  assign synth_accum_en = syn_acc_q;
  assign resamp_accum_en = res_acc_q;
  assign sample_phase_out = sph_q;
  assign sample_strobe_out = sample_strobe_out_q;
  assign clear_targets = clr_q;
  assign decim_filter_cfg = decim_q[tccr_pkg::DECIM_USED_W-1:0];

  // completed write into the chip configuration register
  sequence s_chip_wr;
    psel && penable && pready && pwrite && (paddr == tccr_pkg::ADDR_CHIP);
  endsequence

  // completed write into the decimating filter configuration register
  sequence s_decim_wr;
    psel && penable && pready && pwrite && (paddr == tccr_pkg::ADDR_DECIM);
  endsequence

  // read of the chip configuration register, setup then access
  sequence s_chip_rd;
    psel && !penable && !pwrite && (paddr == tccr_pkg::ADDR_CHIP) ##1 penable;
  endsequence

  // written disable bit shows on the unity output two edges later
  a_agc_unity_wr: assert property (@(posedge pclk) disable iff (!presetn)
    s_chip_wr |-> ##2 (agc_gain_unity == $past(pwdata[tccr_pkg::BIT_AGC_DIS], 2)))
    else $error("gain unity does not follow written disable bit");

  a_level_sense: assert property (@(posedge pclk) disable iff (!presetn)
    live_q |-> level_compare_out == $past(chip_q[tccr_pkg::BIT_LVL_SENSE]
      ? (level_in > level_threshold) : (level_in <= level_threshold)))
    else $error("level compare polarity wrong");

  a_agc_sign: assert property (@(posedge pclk) disable iff (!presetn)
    live_q |-> agc_error_pos == $past((agc_level > agc_threshold)
      ~^ chip_q[tccr_pkg::BIT_AGC_SENSE]))
    else $error("gain loop error sign wrong");

  a_carrier_width: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && $past(chip_q[tccr_pkg::BIT_CAR_EN]) |-> carrier_offset_out ==
      ($past(carrier_offset_in) & ACC_W'(tccr_pkg::width_mask(
        tccr_pkg::tccr_width_t'($past(chip_q[tccr_pkg::FLD_CAR_W +: 2]))))))
    else $error("carrier offset width wrong");

  a_resamp_width: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && $past(chip_q[tccr_pkg::BIT_RES_EN])
      && $past(chip_q[tccr_pkg::FLD_RES_W +: 2]) == 2'b00 |-> resamp_offset_out ==
      ACC_W'($past(resamp_offset_in[7:0])))
    else $error("resampler 8 bit width wrong");

  a_offset_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_q[tccr_pkg::BIT_CAR_EN] && !chip_q[tccr_pkg::BIT_RES_EN] ##1 1
      |-> carrier_offset_out == '0 && resamp_offset_out == '0)
    else $error("disabled offset not zero");

  a_nco_enable: assert property (@(posedge pclk) disable iff (!presetn)
    live_q |-> synth_accum_en == $past(chip_q[tccr_pkg::BIT_SYN_ACC])
      && resamp_accum_en == $past(chip_q[tccr_pkg::BIT_RES_ACC]))
    else $error("nco accumulate enable wrong");

  a_phase_tap: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && $past(chip_q[tccr_pkg::BIT_SPH_CONT]) |-> sample_phase_out ==
      tccr_pkg::SPH_W'($past(resamp_phase_acc)
        >> (tccr_pkg::SPH_BASE + int'($past(chip_q[tccr_pkg::FLD_SPH_SEL +: 2])))))
    else $error("sample phase tap wrong");

  a_phase_hold: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && !chip_q[tccr_pkg::BIT_SPH_CONT] && !output_data_valid
      |=> $stable(sample_phase_out) && $stable(sample_strobe_out))
    else $error("phase pins moved without data valid");

  a_clear_hold: assert property (@(posedge pclk) disable iff (!presetn)
    chip_q[tccr_pkg::BIT_CLEAR] [*2] |-> clear_targets == '1)
    else $error("clear not held while bit set");

  a_clear_release: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && !$past(chip_q[tccr_pkg::BIT_CLEAR]) |-> clear_targets == '0)
    else $error("clear targets active without clear bit");

  a_reserved_rd: assert property (@(posedge pclk) disable iff (!presetn)
    s_chip_rd |-> (prdata & ~tccr_pkg::MASK_CHIP) == '0)
    else $error("reserved bits read nonzero");

  // filter configuration keeps only its used bits from a completed write
  a_decim_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_decim_wr |=> decim_filter_cfg == $past(pwdata[tccr_pkg::DECIM_USED_W-1:0]))
    else $error("filter configuration does not follow write");

  // re-sampler word keeps the low bits chosen by its width code, all four codes
  a_resamp_mask: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && $past(chip_q[tccr_pkg::BIT_RES_EN]) |-> resamp_offset_out ==
      ($past(resamp_offset_in) & ACC_W'(tccr_pkg::width_mask(
        tccr_pkg::tccr_width_t'($past(chip_q[tccr_pkg::FLD_RES_W +: 2]))))))
    else $error("resampler offset width wrong");

  // each enable zeroes its own word, independent of the other one
  a_carrier_off: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && !$past(chip_q[tccr_pkg::BIT_CAR_EN]) |-> carrier_offset_out == '0)
    else $error("disabled carrier offset not zero");

  // the re-sampler enable alone must also force zero
  a_resamp_off: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && !$past(chip_q[tccr_pkg::BIT_RES_EN]) |-> resamp_offset_out == '0)
    else $error("disabled resampler offset not zero");

  // strobe follows its source whenever the phase pins may move
  a_strobe_follow: assert property (@(posedge pclk) disable iff (!presetn)
    live_q && ($past(chip_q[tccr_pkg::BIT_SPH_CONT]) || $past(output_data_valid))
      |-> sample_strobe_out == $past(sample_strobe_in))
    else $error("sample strobe did not follow its source");

  // written clear bit reaches every target two edges after the write
  a_clear_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_chip_wr ##0 pwdata[tccr_pkg::BIT_CLEAR] |-> ##2 clear_targets == '1)
    else $error("clear write did not reach targets");

endmodule // tccr_top

/* tb_tuner_chip_config_reg.sv */
// self-checking testbench for the tuner chip configuration register bank
`timescale 1ns/100ps
module tb_tuner_chip_config_reg;
  logic pclk; // 100 MHz bus clock
  logic presetn; // active-low reset
  logic psel, penable, pwrite; // apb controls
  logic [7:0] paddr; // byte address
  logic [31:0] pwdata, prdata; // apb data
  logic pready, pslverr; // apb answer
  logic [9:0] level_in, level_threshold, agc_level, agc_threshold; // detector inputs
  logic level_compare_out, agc_gain_unity, agc_error_pos; // detector outputs
  logic [31:0] carrier_offset_in, resamp_offset_in; // raw offset words
  logic [31:0] carrier_offset_out, resamp_offset_out; // gated offset words
  logic synth_accum_en, resamp_accum_en; // nco feedback enables
  logic [31:0] resamp_phase_acc; // phase accumulator seen by the tap
  logic output_data_valid, sample_strobe_in; // update gate and strobe source
  logic [4:0] sample_phase_out; // phase pins
  logic sample_strobe_out; // strobe pin
  logic [5:0] clear_targets; // clear lines
  logic [22:0] decim_filter_cfg; // decimating filter controls
  logic [31:0] rd; // last read data
  logic er; // last error flag
  int n_mismatch = 0; // mismatches seen
  int n_tests = 0; // comparisons made

  tccr_top tccr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .level_in(level_in), .level_threshold(level_threshold),
    .level_compare_out(level_compare_out), .agc_level(agc_level),
    .agc_threshold(agc_threshold), .agc_gain_unity(agc_gain_unity),
    .agc_error_pos(agc_error_pos), .carrier_offset_in(carrier_offset_in),
    .resamp_offset_in(resamp_offset_in), .carrier_offset_out(carrier_offset_out),
    .resamp_offset_out(resamp_offset_out), .synth_accum_en(synth_accum_en),
    .resamp_accum_en(resamp_accum_en), .resamp_phase_acc(resamp_phase_acc),
    .output_data_valid(output_data_valid), .sample_strobe_in(sample_strobe_in),
    .sample_phase_out(sample_phase_out), .sample_strobe_out(sample_strobe_out),
    .clear_targets(clear_targets), .decim_filter_cfg(decim_filter_cfg));

  // free-running clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // counts line, verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // four-state compare, so an unknown never passes
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; the wait for pready is bounded so a dead slave ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) got = 1;
    end
    if (got) begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      n_mismatch++;
      summarize();
    end
  endtask

  // let decoded outputs follow a change; they lag by two edges at most
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // write the chip configuration and wait for decoded outputs
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, tccr_pkg::ADDR_CHIP, v);
    settle();
  endtask

  // reset contents, and an unmapped address refused on both directions
  task automatic t_reset();
    apb(1'b0, tccr_pkg::ADDR_CHIP, 32'h0);
    chk("chip reset", 32'h0000_0000, rd);
    chk("chip err", 32'h0, er);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk("unmapped wr err", 32'h1, er);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped rd", 32'h0000_0000, rd);
    chk("unmapped rd err", 32'h1, er);
    apb(1'b0, tccr_pkg::ADDR_DECIM, 32'h0);
    chk("decim reset", 32'h0000_0000, rd);
  endtask

  // reserved upper bits are dropped in both registers
  task automatic t_reserved();
    cfg(32'hFFFF_FFFF);
    apb(1'b0, tccr_pkg::ADDR_CHIP, 32'h0);
    chk("chip reserved", 32'h0000_7FFF, rd);
    apb(1'b1, tccr_pkg::ADDR_DECIM, 32'hFFFF_FFFF);
    apb(1'b0, tccr_pkg::ADDR_DECIM, 32'h0);
    chk("decim reserved", 32'h007F_FFFF, rd);
    apb(1'b1, tccr_pkg::ADDR_DECIM, 32'hA512_3456);
    #1;
    chk("decim cfg", 32'h0012_3456, decim_filter_cfg);
    cfg(32'h0);
  endtask

  // level detector sense, at the threshold and just above it
  task automatic t_level();
    for (int s = 0; s < 2; s++) begin
      cfg(32'(s));
      for (int k = 0; k < 2; k++) begin
        @(posedge pclk);
        level_in <= 10'(10'h100 + k);
        settle();
        chk("level out", 32'((s == 1) ? (k == 1) : (k == 0)), level_compare_out);
      end
    end
  endtask

  // gain loop disable and error sign over all four combinations
  task automatic t_agc();
    for (int v = 0; v < 4; v++) begin
      cfg(32'(v << 1));
      for (int k = 0; k < 2; k++) begin
        @(posedge pclk);
        agc_level <= 10'(10'h080 + k);
        settle();
        chk("agc unity", 32'(v & 1), agc_gain_unity);
        chk("agc error", 32'(((v >> 1) & 1) == k), agc_error_pos);
      end
    end
  endtask

  // width codes and enables of both offset words
  task automatic t_offset();
    logic [31:0] m;
    for (int c = 0; c < 4; c++) begin
      m = (c == 3) ? 32'hFFFF_FFFF : ((32'h1 << (8 * (c + 1))) - 32'h1);
      cfg(32'((c << 3) | ((3 - c) << 5) | 32'h180));
      chk("carrier word", carrier_offset_in & m, carrier_offset_out);
      m = (c == 0) ? 32'hFFFF_FFFF : ((32'h1 << (8 * (4 - c))) - 32'h1);
      chk("resamp word", resamp_offset_in & m, resamp_offset_out);
      cfg(32'((c << 3) | (c << 5)));
      chk("carrier off", 32'h0, carrier_offset_out);
      chk("resamp off", 32'h0, resamp_offset_out);
    end
  endtask

  // nco accumulate enables
  task automatic t_accum();
    for (int v = 0; v < 4; v++) begin
      cfg(32'(v << 9));
      chk("synth acc", 32'(v & 1), synth_accum_en);
      chk("resamp acc", 32'(v >> 1), resamp_accum_en);
    end
  endtask

  // phase tap select with data valid low, then hold and update in gated mode
  task automatic t_phase();
    @(posedge pclk);
    output_data_valid <= 1'b0;
    sample_strobe_in <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      cfg(32'(32'h2000 | (s << 11)));
      chk("phase tap", (resamp_phase_acc >> (24 + s)) & 32'h1F, sample_phase_out);
      chk("strobe cont", 32'h0, sample_strobe_out);
    end
    cfg(32'h0);
    chk("phase gated", 32'h18, sample_phase_out);
    @(posedge pclk);
    resamp_phase_acc <= 32'h4900_0000;
    sample_strobe_in <= 1'b1;
    settle();
    chk("phase hold", 32'h18, sample_phase_out);
    chk("strobe hold", 32'h0, sample_strobe_out);
    @(posedge pclk);
    output_data_valid <= 1'b1;
    settle();
    chk("phase upd", 32'h09, sample_phase_out);
    chk("strobe upd", 32'h1, sample_strobe_out);
  endtask

  // clear is held while the bit is one and released by writing zero
  task automatic t_clear();
    cfg(32'h0000_4780);
    chk("clear on", 32'h3F, clear_targets);
    repeat (20) @(posedge pclk);
    #1;
    chk("clear held", 32'h3F, clear_targets);
    cfg(32'h0000_0780);
    chk("clear off", 32'h0, clear_targets);
  endtask

  // main sequence: all inputs defined at time zero, reset for 16 cycles
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level_in = 10'h000;
    level_threshold = 10'h100;
    agc_level = 10'h000;
    agc_threshold = 10'h080;
    carrier_offset_in = 32'hA5C3_96F1;
    resamp_offset_in = 32'h5A3C_E10F;
    resamp_phase_acc = 32'hC500_0000;
    output_data_valid = 1'b1;
    sample_strobe_in = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_reserved();
    t_level();
    t_agc();
    t_offset();
    t_accum();
    t_phase();
    t_clear();
    summarize();
  end
endmodule // tb_tuner_chip_config_reg
